// ==== hw/gpw_gpio.sv ====
// Ten-pin GPIO block with wake-up, alternative functions and Wishbone registers.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module gpw_gpio
    import gpw_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [GPW_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pads
    input wire logic [GPW_PINS-1:0] pin_i,
    output gpw_pad_t pad_o,
    // Power management
    input wire logic power_down_i,
    output logic wakeup_o,
    // Two-wire bus peripheral
    input wire logic scl_drive_low_i,
    input wire logic sda_drive_low_i,
    output logic scl_o,
    output logic sda_o,
    // RF encoder
    input wire logic encoded_transmit_output_i,
    // Timers
    output logic timer0_gate_input_o,
    output logic timer0_count_input_o,
    output logic timer3_count_input_o,
    // Operating mode straps
    output logic [1:0] operating_mode_o,
    output logic operating_mode_valid_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0] port_a_direction_register;
    logic [7:0] port_a_output_register;
    logic [7:0] port_a_sensitivity_register;
    logic [GPW_B_BITS-1:0] port_b_direction_register;
    logic [GPW_B_BITS-1:0] port_b_output_register;
    logic [GPW_B_BITS-1:0] port_b_sensitivity_register;
    logic [7:0] wakeup_mask_register;
    logic [7:0] configuration_register_one;
    logic [7:0] timer_mode_register;
    logic [7:0] second_timer_mode_register;
    logic [7:0] next_a_dir;
    logic [7:0] next_a_out;
    logic [7:0] next_a_sens;
    logic [GPW_B_BITS-1:0] next_b_dir;
    logic [GPW_B_BITS-1:0] next_b_out;
    logic [GPW_B_BITS-1:0] next_b_sens;
    logic [7:0] next_wum;
    logic [7:0] next_cfg;
    logic [7:0] next_timer_mode_register;
    logic [7:0] next_second_timer_mode_register;

    gpw_bus_state_t bus_state;
    gpw_bus_state_t next_bus_state;
    logic [31:0] next_dat;

    logic [GPW_PINS-1:0] pin_direction_bit;
    logic [GPW_PINS-1:0] pin_output_bit;
    logic [GPW_PINS-1:0] pin_sensitivity_bit;
    logic [GPW_PINS-1:0] pin_filt;
    logic [GPW_PINS-1:0] pin_prev;
    logic [GPW_PINS-1:0] wake_en;
    logic two_wire_bus_enable;
    logic rf_transmit_pin_enable;
    logic [1:0] timer3_clock_select;

    gpw_pad_t next_pad;
    logic next_wakeup;
    logic next_t0_gate;
    logic next_t0_count;
    logic next_t3_count;
    logic [2:0] settle_cnt;
    logic [2:0] next_settle_cnt;
    logic [1:0] next_mode;
    logic next_mode_valid;

    assign pin_direction_bit = {port_b_direction_register, port_a_direction_register};
    assign pin_output_bit = {port_b_output_register, port_a_output_register};
    assign pin_sensitivity_bit = {port_b_sensitivity_register, port_a_sensitivity_register};
    assign two_wire_bus_enable = configuration_register_one[GPW_CFG_TWB_BIT];
    assign rf_transmit_pin_enable = configuration_register_one[GPW_CFG_RFTX_BIT];
    assign timer3_clock_select = second_timer_mode_register[GPW_SECOND_TIMER_MODE_REGISTER_T3_HI:GPW_SECOND_TIMER_MODE_REGISTER_T3_LO];

    ////////////////////////////////////////////////////////////////////////////////
    // Input path.
    gpw_in_filter #(
        .WIDTH(GPW_PINS),
        .RST_VAL(GPW_PIN_RST)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(pin_i),
        .filt_o(pin_filt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave. The write lands on the edge that samples ack, read data
    // are captured one cycle earlier; unmapped addresses answer with zero.
    always_comb begin
        next_bus_state = bus_state;
        next_dat = wb_dat_o;
        next_a_dir = port_a_direction_register;
        next_a_out = port_a_output_register;
        next_a_sens = port_a_sensitivity_register;
        next_b_dir = port_b_direction_register;
        next_b_out = port_b_output_register;
        next_b_sens = port_b_sensitivity_register;
        next_wum = wakeup_mask_register;
        next_cfg = configuration_register_one;
        next_timer_mode_register = timer_mode_register;
        next_second_timer_mode_register = second_timer_mode_register;
        case (bus_state)
            GPW_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    next_bus_state = GPW_BUS_ACK;
                    next_dat = 32'h0;
                    case (wb_adr_i)
                        gpw_byte_adr(GPW_IDX_A_OUT): next_dat[7:0] = port_a_output_register;
                        gpw_byte_adr(GPW_IDX_A_DIR): next_dat[7:0] = port_a_direction_register;
                        gpw_byte_adr(GPW_IDX_A_IN): next_dat[7:0] = pin_filt[7:0];
                        gpw_byte_adr(GPW_IDX_A_SENS): next_dat[7:0] = port_a_sensitivity_register;
                        gpw_byte_adr(GPW_IDX_B_OUT): next_dat[1:0] = port_b_output_register;
                        gpw_byte_adr(GPW_IDX_B_DIR): next_dat[1:0] = port_b_direction_register;
                        gpw_byte_adr(GPW_IDX_B_IN): next_dat[1:0] = pin_filt[9:8];
                        gpw_byte_adr(GPW_IDX_B_SENS): next_dat[1:0] = port_b_sensitivity_register;
                        gpw_byte_adr(GPW_IDX_WUM): next_dat[7:0] = wakeup_mask_register;
                        gpw_byte_adr(GPW_IDX_CONFIGURATION_REGISTER_ONE): next_dat[7:0] = configuration_register_one;
                        gpw_byte_adr(GPW_IDX_TIMER_MODE_REGISTER): next_dat[7:0] = timer_mode_register;
                        gpw_byte_adr(GPW_IDX_SECOND_TIMER_MODE_REGISTER): next_dat[7:0] = second_timer_mode_register;
                        default: next_dat = 32'h0;
                    endcase
                end
            end
            GPW_BUS_ACK: begin
                next_bus_state = GPW_BUS_IDLE;
                // Configuration is frozen in power-down so pins keep their state.
                if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !power_down_i) begin
                    case (wb_adr_i)
                        gpw_byte_adr(GPW_IDX_A_OUT): next_a_out = wb_dat_i[7:0];
                        gpw_byte_adr(GPW_IDX_A_DIR): next_a_dir = wb_dat_i[7:0];
                        gpw_byte_adr(GPW_IDX_A_SENS): next_a_sens = wb_dat_i[7:0];
                        gpw_byte_adr(GPW_IDX_B_OUT): next_b_out = wb_dat_i[1:0];
                        gpw_byte_adr(GPW_IDX_B_DIR): next_b_dir = wb_dat_i[1:0];
                        gpw_byte_adr(GPW_IDX_B_SENS): next_b_sens = wb_dat_i[1:0];
                        gpw_byte_adr(GPW_IDX_WUM): next_wum = wb_dat_i[7:0];
                        gpw_byte_adr(GPW_IDX_CONFIGURATION_REGISTER_ONE): next_cfg = wb_dat_i[7:0];
                        gpw_byte_adr(GPW_IDX_TIMER_MODE_REGISTER): next_timer_mode_register = wb_dat_i[7:0];
                        gpw_byte_adr(GPW_IDX_SECOND_TIMER_MODE_REGISTER): next_second_timer_mode_register = wb_dat_i[7:0];
                        default: next_second_timer_mode_register = second_timer_mode_register;
                    endcase
                end
            end
            default: next_bus_state = GPW_BUS_IDLE;
        endcase
    end

    assign wb_ack_o = (bus_state == GPW_BUS_ACK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state <= GPW_BUS_IDLE;
            wb_dat_o <= 32'h0;
            port_a_direction_register <= GPW_DIR_RST;
            port_a_output_register <= GPW_OUT_RST;
            port_a_sensitivity_register <= GPW_SENS_RST;
            port_b_direction_register <= GPW_DIR_RST[GPW_B_BITS-1:0];
            port_b_output_register <= GPW_OUT_RST[GPW_B_BITS-1:0];
            port_b_sensitivity_register <= GPW_SENS_RST[GPW_B_BITS-1:0];
            wakeup_mask_register <= GPW_WUM_RST;
            configuration_register_one <= GPW_CFG_RST;
            timer_mode_register <= GPW_TIMER_MODE_REGISTER_RST;
            second_timer_mode_register <= GPW_TIMER_MODE_REGISTER_RST;
        end else begin
            bus_state <= next_bus_state;
            wb_dat_o <= next_dat;
            port_a_direction_register <= next_a_dir;
            port_a_output_register <= next_a_out;
            port_a_sensitivity_register <= next_a_sens;
            port_b_direction_register <= next_b_dir;
            port_b_output_register <= next_b_out;
            port_b_sensitivity_register <= next_b_sens;
            wakeup_mask_register <= next_wum;
            configuration_register_one <= next_cfg;
            timer_mode_register <= next_timer_mode_register;
            second_timer_mode_register <= next_second_timer_mode_register;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad drive: standard configuration first, peripheral functions on top.
    always_comb begin
        next_pad = '0;
        for (int p = 0; p < GPW_PINS; p++) begin
            if (!pin_direction_bit[p]) begin
                next_pad.oe[p] = 1'b1;
                next_pad.dout[p] = pin_output_bit[p];
            end else begin
                // Pull follows output and sensitivity, also for wake-up pins.
                next_pad.pull_up[p] = pin_output_bit[p] & ~pin_sensitivity_bit[p];
                next_pad.pull_down[p] = pin_output_bit[p] & pin_sensitivity_bit[p];
            end
        end
        // Open-drain two-wire lines only ever pull low; the weak high stays on.
        if (two_wire_bus_enable) begin
            next_pad.dout[1:0] = 2'h0;
            next_pad.oe[0] = scl_drive_low_i;
            next_pad.oe[1] = sda_drive_low_i;
            next_pad.pull_up[1:0] = 2'h3;
            next_pad.pull_down[1:0] = 2'h0;
        end
        if (rf_transmit_pin_enable) begin
            next_pad.oe[2] = 1'b1;
            next_pad.dout[2] = encoded_transmit_output_i;
            next_pad.pull_up[2] = 1'b0;
            next_pad.pull_down[2] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wake-up: pins 1-4 use mask bits 0-3, pins 6-9 use mask bits 4-7.
    always_comb begin
        wake_en = '0;
        for (int p = 1; p < GPW_PINS; p++) begin
            if (p < 5) begin
                wake_en[p] = ~wakeup_mask_register[p-1] & pin_direction_bit[p];
            end else if (p > 5) begin
                wake_en[p] = ~wakeup_mask_register[p-2] & pin_direction_bit[p];
            end
        end
        // Sensitivity 0 is active low, 1 active high.
        next_wakeup = |(wake_en & ~(pin_filt ^ pin_sensitivity_bit));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer inputs and strap capture.
    always_comb begin
        next_t0_gate = timer_mode_register[GPW_TIMER_MODE_REGISTER_GATE_BIT] ? pin_filt[0] : 1'b1;
        next_t0_count = timer_mode_register[GPW_TIMER_MODE_REGISTER_CT_BIT]
            & pin_filt[1] & ~pin_prev[1];
        next_t3_count = (timer3_clock_select == GPW_T3_SRC_PIN)
            & pin_filt[2] & ~pin_prev[2];
        next_settle_cnt = settle_cnt;
        next_mode = operating_mode_o;
        next_mode_valid = operating_mode_valid_o;
        if (!operating_mode_valid_o) begin
            if (settle_cnt == 3'(GPW_MODE_SETTLE_CYC - 1)) begin
                next_mode = pin_filt[1:0];
                next_mode_valid = 1'b1;
            end else begin
                next_settle_cnt = settle_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_o <= '{dout: '0, oe: '0, pull_up: GPW_PIN_RST, pull_down: '0};
            pin_prev <= GPW_PIN_RST;
            wakeup_o <= 1'b0;
            scl_o <= 1'b1;
            sda_o <= 1'b1;
            timer0_gate_input_o <= 1'b1;
            timer0_count_input_o <= 1'b0;
            timer3_count_input_o <= 1'b0;
            settle_cnt <= 3'h0;
            operating_mode_o <= 2'h0;
            operating_mode_valid_o <= 1'b0;
        end else begin
            pad_o <= next_pad;
            pin_prev <= pin_filt;
            wakeup_o <= next_wakeup;
            scl_o <= pin_filt[0];
            sda_o <= pin_filt[1];
            timer0_gate_input_o <= next_t0_gate;
            timer0_count_input_o <= next_t0_count;
            timer3_count_input_o <= next_t3_count;
            settle_cnt <= next_settle_cnt;
            operating_mode_o <= next_mode;
            operating_mode_valid_o <= next_mode_valid;
        end
    end

endmodule : gpw_gpio

// ==== inc/gpw_pkg.sv ====
// Shared constants, register map and types of the ten-pin GPIO block.
package gpw_pkg;

    localparam int GPW_PINS = 10;
    localparam int GPW_ADR_W = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] GPW_IDX_A_OUT = 8'h90;
    localparam logic [7:0] GPW_IDX_A_DIR = 8'h91;
    localparam logic [7:0] GPW_IDX_A_IN = 8'h92;
    localparam logic [7:0] GPW_IDX_A_SENS = 8'h93;
    localparam logic [7:0] GPW_IDX_B_OUT = 8'hB0;
    localparam logic [7:0] GPW_IDX_B_DIR = 8'hEB;
    localparam logic [7:0] GPW_IDX_B_IN = 8'hEC;
    localparam logic [7:0] GPW_IDX_B_SENS = 8'hED;
    localparam logic [7:0] GPW_IDX_SECOND_TIMER_MODE_REGISTER = 8'hC9;
    localparam logic [7:0] GPW_IDX_TIMER_MODE_REGISTER = 8'h89;
    localparam logic [7:0] GPW_IDX_CONFIGURATION_REGISTER_ONE = 8'hDA;
    localparam logic [7:0] GPW_IDX_WUM = 8'hDB;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] GPW_DIR_RST = 8'hFF;
    localparam logic [7:0] GPW_OUT_RST = 8'hFF;
    localparam logic [7:0] GPW_SENS_RST = 8'h00;
    localparam logic [7:0] GPW_WUM_RST = 8'hFF;
    localparam logic [7:0] GPW_CFG_RST = 8'h00;
    localparam logic [7:0] GPW_TIMER_MODE_REGISTER_RST = 8'h00;
    localparam logic [GPW_PINS-1:0] GPW_PIN_RST = 10'h3FF;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and codes.
    localparam int GPW_CFG_TWB_BIT = 6;
    localparam int GPW_CFG_RFTX_BIT = 4;
    localparam int GPW_TIMER_MODE_REGISTER_GATE_BIT = 3;
    localparam int GPW_TIMER_MODE_REGISTER_CT_BIT = 2;
    localparam int GPW_SECOND_TIMER_MODE_REGISTER_T3_HI = 7;
    localparam int GPW_SECOND_TIMER_MODE_REGISTER_T3_LO = 6;
    localparam logic [1:0] GPW_T3_SRC_PIN = 2'h3;
    localparam int GPW_B_BITS = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: strap pins are sampled once this many cycles after reset release.
    // The pin filter restarts at its reset level, so capture waits until it has flushed.
    localparam int GPW_MODE_SETTLE_CYC = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef struct packed {
        logic [GPW_PINS-1:0] dout;
        logic [GPW_PINS-1:0] oe;
        logic [GPW_PINS-1:0] pull_up;
        logic [GPW_PINS-1:0] pull_down;
    } gpw_pad_t;

    typedef enum logic [1:0] {
        GPW_BUS_IDLE = 2'b01,
        GPW_BUS_ACK = 2'b10
    } gpw_bus_state_t;

    function automatic logic [GPW_ADR_W-1:0] gpw_byte_adr(input logic [7:0] idx);
        gpw_byte_adr = {2'h0, idx, 2'h0};
    endfunction : gpw_byte_adr

endpackage : gpw_pkg

// ==== hw/gpw_in_filter.sv ====
// Two-flop synchroniser followed by a two-stage spike filter, one lane per pin.
`timescale 1ns/1ps
module gpw_in_filter #(
    parameter int WIDTH = 10,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw pins and filtered levels
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] filt_o
);

    logic [WIDTH-1:0] sync_a;
    logic [WIDTH-1:0] sync_b;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;
    logic [WIDTH-1:0] next_filt;

    // A level must be seen on two successive samples before it is passed,
    // so a one-cycle spike never reaches the output.
    always_comb begin
        next_stage = sync_b;
        for (int i = 0; i < WIDTH; i++) begin
            next_filt[i] = (sync_b[i] == stage[i]) ? stage[i] : filt_o[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= RST_VAL;
            sync_b <= RST_VAL;
            stage <= RST_VAL;
            filt_o <= RST_VAL;
        end else begin
            sync_a <= raw_i;
            sync_b <= sync_a;
            stage <= next_stage;
            filt_o <= next_filt;
        end
    end

endmodule : gpw_in_filter

// ==== test/gpw_gpio_chk.sv ====
// Port-level assertions for the ten-pin GPIO block.
`timescale 1ns/1ps
module gpw_gpio_chk
    import gpw_pkg::*;
(
    // Clock, reset and bus handshake
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Pins and power
    input wire logic [GPW_PINS-1:0] pin_i,
    input wire gpw_pad_t pad_o,
    input wire logic power_down_i,
    // Filtered and alternative outputs
    input wire logic scl_o,
    input wire logic timer0_gate_input_o,
    input wire logic timer0_count_input_o,
    input wire logic timer3_count_input_o,
    input wire logic [1:0] operating_mode_o,
    input wire logic operating_mode_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_reset_pads: assert property ($fell(rst_i) |->
        pad_o.oe == '0 && pad_o.pull_down == '0 && pad_o.pull_up == GPW_PIN_RST)
        else $error("pads not pulled-up inputs after reset");
    a_pull_exclusive: assert property ((pad_o.pull_up & pad_o.pull_down) == '0)
        else $error("pull-up and pull-down together");
    a_drive_no_pull: assert property (
        (pad_o.oe[9:2] & (pad_o.pull_up[9:2] | pad_o.pull_down[9:2])) == '0)
        else $error("driven pin with pull");
    a_spike_filter: assert property ($changed(scl_o) |->
        $past(pin_i[0], 4) == scl_o && $past(pin_i[0], 5) == scl_o)
        else $error("clock line changed without a stable pin");
    a_gate_follow: assert property ($fell(timer0_gate_input_o) |->
        !$past(pin_i[0], 4) && !$past(pin_i[0], 5)) else $error("gate fell without pin low");
    a_t0_edge: assert property (timer0_count_input_o |->
        $past(pin_i[1], 4) && $past(pin_i[1], 5) ##1 !timer0_count_input_o)
        else $error("timer 0 count without pin edge");
    a_t3_edge: assert property (timer3_count_input_o |->
        $past(pin_i[2], 4) && $past(pin_i[2], 5) ##1 !timer3_count_input_o)
        else $error("timer 3 count without pin edge");
    a_pd_freeze: assert property (power_down_i && $past(power_down_i) |=> $stable(pad_o))
        else $error("pads changed in power-down");
    a_mode_hold: assert property (operating_mode_valid_o |=>
        operating_mode_valid_o && $stable(operating_mode_o)) else $error("mode not held");
endmodule : gpw_gpio_chk

// ==== test/gpw_board.sv ====
// Behavioural board around the pins: external drivers, pull resistors and open lines.
`timescale 1ns/1ps
module gpw_board
    import gpw_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pad controls and test drivers
    input wire gpw_pad_t pad_i,
    input wire logic [GPW_PINS-1:0] drv_en_i,
    input wire logic [GPW_PINS-1:0] drv_val_i,
    // Resolved levels
    output logic [GPW_PINS-1:0] pin_o
);
    logic [GPW_PINS-1:0] flt = 10'h155;
    // An open line toggles so that it never looks like a settled level.
    always @(posedge clk_i) begin
        flt <= ~flt;
    end
    always_comb begin
        for (int k = 0; k < GPW_PINS; k++) begin
            pin_o[k] = pad_i.oe[k] ? pad_i.dout[k] : drv_en_i[k] ? drv_val_i[k] :
                pad_i.pull_up[k] ? 1'b1 : pad_i.pull_down[k] ? 1'b0 : flt[k];
        end
    end
endmodule : gpw_board

// ==== test/gpw_gpio_tb.sv ====
// Self-checking testbench of the GPIO block against expected values worked out in the test.
`timescale 1ns/1ps
module gpw_gpio_tb;
    import gpw_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic pd = 1'b0;
    logic scl_lo = 1'b0;
    logic sda_lo = 1'b0;
    logic enc = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [GPW_ADR_W-1:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat, q;
    logic ack, wake, scl, sda, t0g, t0c, t3c, mode_v;
    logic [1:0] mode;
    logic [GPW_PINS-1:0] pins;
    logic [GPW_PINS-1:0] ext_en = '0;
    logic [GPW_PINS-1:0] ext_val = '0;
    gpw_pad_t pad;
    int n_mismatch = 0;
    int check_count = 0;
    int n_t0 = 0;
    int n_t3 = 0;
    int m_dir, m_out, m_sens;
    logic [7:0] ridx [7] = '{GPW_IDX_A_DIR, GPW_IDX_A_OUT, GPW_IDX_A_SENS, GPW_IDX_B_DIR,
        GPW_IDX_B_OUT, GPW_IDX_B_SENS, GPW_IDX_WUM};
    logic [7:0] rrst [7] = '{8'hFF, 8'hFF, 8'h00, 8'h03, 8'h03, 8'h00, 8'hFF};

    gpw_gpio gpw_gpio_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_i(pins), .pad_o(pad), .power_down_i(pd), .wakeup_o(wake),
        .scl_drive_low_i(scl_lo), .sda_drive_low_i(sda_lo), .scl_o(scl), .sda_o(sda),
        .encoded_transmit_output_i(enc), .timer0_gate_input_o(t0g),
        .timer0_count_input_o(t0c), .timer3_count_input_o(t3c),
        .operating_mode_o(mode), .operating_mode_valid_o(mode_v)
    );
    gpw_board gpw_board_i (.clk_i(clk_i), .pad_i(pad), .drv_en_i(ext_en), .drv_val_i(ext_val),
        .pin_o(pins));

    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (t3c === 1'b1) n_t3++;
        if (t0c === 1'b1) n_t0++;
    end
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // Read data is taken at the edge that sees ack, before that edge's updates land.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chk(1'b0, 1'b1);
    endtask : wb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk(q, {24'h0, e});
    endtask : rdc
    task automatic set_pins(input int d, input int o, input int s);
        m_dir = d & 'h3FF;
        m_out = o & 'h3FF;
        m_sens = s & 'h3FF;
        wr(GPW_IDX_A_DIR, m_dir[7:0]);
        wr(GPW_IDX_B_DIR, {6'h0, m_dir[9:8]});
        wr(GPW_IDX_A_OUT, m_out[7:0]);
        wr(GPW_IDX_B_OUT, {6'h0, m_out[9:8]});
        wr(GPW_IDX_A_SENS, m_sens[7:0]);
        wr(GPW_IDX_B_SENS, {6'h0, m_sens[9:8]});
    endtask : set_pins
    task automatic pad_chk();
        tick(2);
        chk(pad.oe, ~m_dir & 'h3FF);
        chk(pad.dout & pad.oe, m_out & ~m_dir & 'h3FF);
        chk(pad.pull_up, m_dir & m_out & ~m_sens & 'h3FF);
        chk(pad.pull_down, m_dir & m_out & m_sens);
    endtask : pad_chk
    ////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk_i);
        chk(1'b0, 1'b1);
        tally_and_finish();
    end
    initial begin
        q = $urandom(87);
        tick(4);
        rst_i <= 1'b0;
        tick(6);
        chk({mode_v, mode}, 3'h7);
        for (int k = 0; k < 7; k++) rdc(ridx[k], rrst[k]);
        rdc(8'h00, 8'h00);
        m_dir = 'h3FF;
        m_out = 'h3FF;
        m_sens = 0;
        pad_chk();
        repeat (6) begin
            set_pins($urandom, $urandom, $urandom);
            pad_chk();
        end
        sel <= 4'h0;
        wr(GPW_IDX_A_DIR, ~m_dir[7:0]);
        sel <= 4'hF;
        pd <= 1'b1;
        wr(GPW_IDX_A_DIR, ~m_dir[7:0]);
        rdc(GPW_IDX_A_DIR, m_dir[7:0]);
        pad_chk();
        pd <= 1'b0;
        set_pins('h3FF, 0, 0);
        ext_en <= '1;
        repeat (4) begin
            ext_val <= 10'($urandom);
            tick(6);
            rdc(GPW_IDX_A_IN, ext_val[7:0]);
            rdc(GPW_IDX_B_IN, {6'h0, ext_val[9:8]});
        end
        wr(GPW_IDX_SECOND_TIMER_MODE_REGISTER, 8'hC0);
        wr(GPW_IDX_TIMER_MODE_REGISTER, 8'h0C);
        ext_val <= '0;
        tick(8);
        // Pulse lengths one to four cycles on pins 1 and 2 together.
        for (int l = 1; l < 5; l++) begin
            n_t0 = 0;
            n_t3 = 0;
            ext_val[2:1] <= 2'h3;
            tick(l);
            ext_val[2:1] <= 2'h0;
            tick(8);
            chk(n_t3, l > 1);
            chk(n_t0, l > 1);
        end
        chk(t0g, 1'b0);
        ext_val[0] <= 1'b1;
        tick(8);
        chk(t0g, 1'b1);
        wr(GPW_IDX_TIMER_MODE_REGISTER, 8'h00);
        ext_val[0] <= 1'b0;
        tick(8);
        chk(t0g, 1'b1);
        // A source code other than 11 and a cleared count select must not count.
        wr(GPW_IDX_SECOND_TIMER_MODE_REGISTER, 8'h80);
        n_t0 = 0;
        n_t3 = 0;
        ext_val[2:1] <= 2'h3;
        tick(8);
        chk(n_t3, 0);
        chk(n_t0, 0);
        ext_val[2:1] <= 2'h0;
        set_pins('h3FF, 'h3FF, 'h004);
        wr(GPW_IDX_WUM, 8'hFC);
        ext_en <= '0;
        pad_chk();
        tick(8);
        chk(wake, 1'b0);
        for (int k = 1; k < 4; k++) begin
            ext_en[k] <= 1'b1;
            ext_val[k] <= (k == 2);
            tick(8);
            chk(wake, k < 3);
            ext_en[k] <= 1'b0;
            tick(8);
            chk(wake, 1'b0);
        end
        set_pins('h3FD, 'h3FD, 'h004);
        tick(8);
        chk(wake, 1'b0);
        set_pins('h3FC, 'h3FF, 0);
        wr(GPW_IDX_CONFIGURATION_REGISTER_ONE, 8'h40);
        tick(2);
        chk({pad.oe[1:0], pad.pull_up[1:0]}, 4'h3);
        scl_lo <= 1'b1;
        tick(8);
        chk({pad.oe[0], pad.dout[0], scl}, 3'h4);
        scl_lo <= 1'b0;
        sda_lo <= 1'b1;
        tick(8);
        chk({pad.oe[1], pad.dout[1], sda, scl}, 4'h9);
        sda_lo <= 1'b0;
        wr(GPW_IDX_CONFIGURATION_REGISTER_ONE, 8'h10);
        for (int v = 0; v < 2; v++) begin
            enc <= v[0];
            tick(2);
            chk({pad.oe[2], pad.dout[2], pad.pull_up[2]}, {1'b1, v[0], 1'b0});
        end
        // Second reset with straps pin 1 low and pin 0 high.
        ext_en <= 10'h003;
        ext_val <= 10'h001;
        rst_i <= 1'b1;
        tick(4);
        rst_i <= 1'b0;
        tick(6);
        chk({mode_v, mode}, 3'h5);
        m_dir = 'h3FF;
        m_out = 'h3FF;
        m_sens = 0;
        pad_chk();
        rdc(GPW_IDX_CONFIGURATION_REGISTER_ONE, 8'h00);
        tally_and_finish();
    end
endmodule : gpw_gpio_tb

bind gpw_gpio gpw_gpio_chk gpw_gpio_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pad_o(pad_o), .power_down_i(power_down_i),
    .scl_o(scl_o), .timer0_gate_input_o(timer0_gate_input_o),
    .timer0_count_input_o(timer0_count_input_o), .timer3_count_input_o(timer3_count_input_o),
    .operating_mode_o(operating_mode_o), .operating_mode_valid_o(operating_mode_valid_o)
);
